// ---- cifd_pkg.sv ----
// Purpose: shared constants for the contact input function dispatcher
// Assumes: 125 MHz system clock
// Notes:   function codes are the per-contact configuration values
package cifd_pkg;
  localparam int unsigned NUM_CONTACTS   = 5;
  localparam int unsigned NUM_FUNCS      = 14;
  localparam int unsigned FUNC_W         = 5;
  localparam int unsigned NUM_ALARMS     = 4;
  localparam int unsigned NUM_KEYS       = 6;
  localparam int unsigned CODE_INPUTS    = 4;
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned CLOSE_DELAY_MS = 1000;
  localparam int unsigned CLOSE_DELAY_CYC = CLOSE_DELAY_MS * (CLK_HZ / 1000);

  typedef logic [FUNC_W-1:0] cifd_func_t;

  localparam cifd_func_t CF_REPORT_ONLY   = 5'h00;
  localparam cifd_func_t CF_CODED_SP      = 5'h01;
  localparam cifd_func_t CF_REMOTE_SP     = 5'h02;
  localparam cifd_func_t CF_MANUAL_TRIP   = 5'h03;
  localparam cifd_func_t CF_SECOND_SP     = 5'h04;
  localparam cifd_func_t CF_ALT_TUNING    = 5'h05;
  localparam cifd_func_t CF_ALARM_ACK     = 5'h06;
  localparam cifd_func_t CF_INTEG_INHIBIT = 5'h07;
  localparam cifd_func_t CF_ACTION_REV    = 5'h08;
  localparam cifd_func_t CF_ADAPT_SUSPEND = 5'h09;
  localparam cifd_func_t CF_LOCKED_MANUAL = 5'h0a;
  localparam cifd_func_t CF_KEY_MIMIC     = 5'h0b;
  localparam cifd_func_t CF_PROC_SWITCH   = 5'h0c;
  localparam cifd_func_t CF_NONE          = 5'h0d;

  // key mimic selectors: raise, lower, display, fast, menu
  localparam logic [2:0] KEY_UP    = 3'h0;
  localparam logic [2:0] KEY_DOWN  = 3'h1;
  localparam logic [2:0] KEY_DISP  = 3'h2;
  localparam logic [2:0] KEY_FAST  = 3'h3;
  localparam logic [2:0] KEY_MENU  = 3'h4;

  localparam logic [2:0] SP_INDEX_RST  = 3'h0;
  localparam logic [2:0] SP_INDEX_SEC  = 3'h1;
  localparam logic [3:0] CODE_MAX      = 4'h8;
endpackage

// ---- cifd_contact_if.sv ----
// Purpose: qualified contact levels and edges between dispatcher parts
// Assumes: all signals on clk
// Notes:   rise and fall are one-cycle pulses
interface cifd_contact_if #(parameter int unsigned N = 5);
  logic [N-1:0] closed;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output closed, output rise, output fall);
  modport dst (input closed, input rise, input fall);
endinterface

// ---- cifd_contact_cond.sv ----
// Purpose: synchronise contacts and qualify closures after a hold delay
// Assumes: raw contacts are asynchronous, high means closed
// Notes:   opening is seen at once, closing only after DELAY cycles
module cifd_contact_cond #(
  parameter int unsigned N     = 5,
  parameter int unsigned DELAY = 125_000_000
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [N-1:0] contact_raw,
  cifd_contact_if.src       cif
);
  localparam int unsigned CW = $clog2(DELAY + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY - 1);

  logic [N-1:0]        sync1_q;
  logic [N-1:0]        sync2_q;
  logic [N-1:0]        closed_q;
  logic [N-1:0]        rise_q;
  logic [N-1:0]        fall_q;
  logic [N-1:0][CW-1:0] cnt_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= contact_raw;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q    <= '0;
      closed_q <= '0;
      rise_q   <= '0;
      fall_q   <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        rise_q[i] <= 1'b0;
        fall_q[i] <= 1'b0;
        if (!sync2_q[i])
        begin
          cnt_q[i]    <= '0;
          closed_q[i] <= 1'b0;
          fall_q[i]   <= closed_q[i];
        end
        else if (!closed_q[i])
        begin
          if (cnt_q[i] == LAST)
          begin
            closed_q[i] <= 1'b1;
            rise_q[i]   <= 1'b1;
          end
          else
            cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end

  assign cif.closed = closed_q;
  assign cif.rise   = rise_q;
  assign cif.fall   = fall_q;

  sequence s_open_seen;
    !sync2_q[0] ##1 1'b1;
  endsequence

  AST_OPEN_FAST: assert property (@(posedge clk) disable iff (!reset_n)
    s_open_seen |-> !closed_q[0])
    else $error("contact still closed after opening");
  AST_RISE_HELD: assert property (@(posedge clk) disable iff (!reset_n)
    rise_q[0] |-> closed_q[0] && $past(sync2_q[0], 2))
    else $error("closure edge without a held contact");
endmodule

// ---- cifd_recency.sv ----
// Purpose: rank contacts by closure order and pick the newest requester
// Assumes: rise pulses come from the contact conditioner
// Notes:   rank 0 is the most recent closure; ties go to lower index
module cifd_recency #(
  parameter int unsigned N = 5
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  cifd_contact_if.dst       cif,
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] newest
);
  logic [N-1:0][2:0] rank_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rank_q <= '1;
    else
      for (int i = 0; i < N; i++)
      begin
        if (cif.rise[i])
          rank_q[i] <= 3'h0;
        else if (|cif.rise && rank_q[i] != 3'h7)
          rank_q[i] <= rank_q[i] + 3'h1;
      end
  end

  always_comb
  begin
    logic [2:0] best;
    best   = 3'h7;
    newest = '0;
    for (int i = 0; i < N; i++)
      if (req[i] && (newest == '0 || rank_q[i] < best))
      begin
        best   = rank_q[i];
        newest = '0;
        newest[i] = 1'b1;
      end
  end
endmodule

// ---- cifd_dispatch.sv ----
// Purpose: dispatch contact inputs to setpoint, mode and tuning actions
// Assumes: config ports are static between changes; pulses are one cycle
// Notes:   control logic reads the registered outputs below
//
// Overview of operation
// - five contacts, each one of fourteen functions
// - inputs one to four code setpoints
// - coded choice holds; rearms on combination change
// - remote contact selects remote, open reverts
// - manual trip contact; keys and comms override
// - second setpoint contact, open reverts
// - tuning set two, else trip points
// - alarm acknowledge once per closure
// - acknowledge only acknowledgeable alarms
// - integral term off while closed
// - invert first output action while closed
// - adaptive tuning suspended while closed
// - locked manual until all opened
// - contact mimics the assigned front key
// - report only: status to comms only
// - process switch selects second process input
// - newest remote or second closure wins; either beats coded
// - overridden contact ignored until reopened
// - contact manual leaves secondary display
// - act one second after closure
module cifd_dispatch
  import cifd_pkg::*;
#(
  parameter int unsigned CLOSE_DELAY_CYCLES = cifd_pkg::CLOSE_DELAY_CYC
) (
  input  wire logic                                     clk,
  input  wire logic                                     reset_n,
  input  wire logic [cifd_pkg::NUM_CONTACTS-1:0]        contact_raw,
  input  wire cifd_pkg::cifd_func_t [cifd_pkg::NUM_CONTACTS-1:0] contact_func,
  input  wire logic [cifd_pkg::NUM_CONTACTS-1:0][2:0]   key_select,
  input  wire logic [2:0]                               local_sp_index,
  input  wire logic                                     local_sp_remote,
  input  wire logic                                     sp_override,
  input  wire logic                                     manual_override,
  input  wire logic                                     pid_linked_to_sp,
  input  wire logic                                     process_input_source,
  input  wire logic                                     cfg_action_direct,
  input  wire logic [cifd_pkg::NUM_ALARMS-1:0]          alarm_active,
  input  wire logic [cifd_pkg::NUM_ALARMS-1:0]          alarm_ackable,
  output logic      [2:0]                               sp_index_q,
  output logic                                          sp_remote_q,
  output logic                                          manual_mode_q,
  output logic                                          locked_manual_q,
  output logic                                          hold_second_display_q,
  output logic                                          tuning_set_two_q,
  output logic      [cifd_pkg::NUM_ALARMS-1:0]          alarm_ack_q,
  output logic                                          integral_inhibit_q,
  output logic                                          action_direct_q,
  output logic                                          adaptive_suspend_q,
  output logic      [cifd_pkg::NUM_KEYS-1:0]            key_mimic_q,
  output logic      [cifd_pkg::NUM_CONTACTS-1:0]        report_status_q,
  output logic                                          use_pv2_q
);
  import cifd_pkg::*;
  localparam int unsigned N = NUM_CONTACTS;

  cifd_contact_if #(.N(N)) cif ();

  logic [N-1:0]            is_coded;
  logic [N-1:0]            is_remote;
  logic [N-1:0]            is_second;
  logic [N-1:0]            is_manual;
  logic [N-1:0]            is_alt;
  logic [N-1:0]            sp_group;
  logic [N-1:0]            armed_q;
  logic [N-1:0]            sp_newest;
  logic [N-1:0]            active;
  logic [CODE_INPUTS-1:0]  code_now;
  logic [CODE_INPUTS-1:0]  code_q;
  logic                    code_armed_q;
  logic                    coded_mode;
  logic                    code_valid;
  logic                    ack_fire;
  logic                    locked_req;

  function automatic logic [N-1:0] func_mask(input cifd_func_t f,
                                             input cifd_func_t [N-1:0] cfg,
                                             input logic coded);
    logic [N-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++)
      m[i] = (cfg[i] == f) && !(coded && i < CODE_INPUTS);
    return m;
  endfunction

  cifd_contact_cond #(
    .N     (N),
    .DELAY (CLOSE_DELAY_CYCLES)
  ) u_cond (
    .clk         (clk),
    .reset_n     (reset_n),
    .contact_raw (contact_raw),
    .cif         (cif)
  );

  // coded selection takes inputs one to four from the other functions
  assign coded_mode = (contact_func[0] == CF_CODED_SP);
  assign code_now   = cif.closed[CODE_INPUTS-1:0];
  assign code_valid = (code_q != 4'h0) && (code_q <= CODE_MAX);

  assign is_coded  = coded_mode ? N'(4'hf) : '0;
  assign is_remote = func_mask(CF_REMOTE_SP, contact_func, coded_mode);
  assign is_second = func_mask(CF_SECOND_SP, contact_func, coded_mode);
  assign is_manual = func_mask(CF_MANUAL_TRIP, contact_func, coded_mode);
  assign is_alt    = func_mask(CF_ALT_TUNING, contact_func, coded_mode);
  assign sp_group  = is_remote | is_second;
  assign active    = armed_q & cif.closed;
  assign locked_req = |(cif.closed & func_mask(CF_LOCKED_MANUAL, contact_func, coded_mode));

  cifd_recency #(.N(N)) u_rank (
    .clk     (clk),
    .reset_n (reset_n),
    .cif     (cif),
    .req     (active & sp_group),
    .newest  (sp_newest)
  );

  // armed: set by a fresh closure, cleared by an override; set wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      armed_q <= '0;
    else
      for (int i = 0; i < N; i++)
      begin
        if (cif.rise[i])
          armed_q[i] <= 1'b1;
        else if (!cif.closed[i])
          armed_q[i] <= 1'b0;
        else if (sp_group[i] && (sp_override || |(cif.rise & sp_group)))
          armed_q[i] <= 1'b0;
        else if (is_manual[i] && manual_override)
          armed_q[i] <= 1'b0;
        else if (is_alt[i] && pid_linked_to_sp && sp_override)
          armed_q[i] <= 1'b0;
      end
  end

  // coded selection latch and rearm on combination change
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      code_q       <= '0;
      code_armed_q <= 1'b0;
    end
    else if (!coded_mode)
    begin
      code_q       <= '0;
      code_armed_q <= 1'b0;
    end
    else if (code_now != code_q)
    begin
      code_q       <= code_now;
      code_armed_q <= 1'b1;
    end
    else if (sp_override || |(cif.rise & sp_group))
      code_armed_q <= 1'b0;
  end

  // setpoint source
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sp_index_q  <= SP_INDEX_RST;
      sp_remote_q <= 1'b0;
    end
    else if (|(sp_newest & is_remote))
    begin
      sp_index_q  <= local_sp_index;
      sp_remote_q <= 1'b1;
    end
    else if (|(sp_newest & is_second))
    begin
      sp_index_q  <= SP_INDEX_SEC;
      sp_remote_q <= 1'b0;
    end
    else if (code_armed_q && code_valid)
    begin
      sp_index_q  <= 3'(code_q - 4'h1);
      sp_remote_q <= 1'b0;
    end
    else
    begin
      sp_index_q  <= local_sp_index;
      sp_remote_q <= local_sp_remote;
    end
  end

  // control mode
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      manual_mode_q         <= 1'b0;
      locked_manual_q       <= 1'b0;
      hold_second_display_q <= 1'b0;
    end
    else
    begin
      locked_manual_q <= |(cif.closed & func_mask(CF_LOCKED_MANUAL, contact_func,
                                                 coded_mode));
      manual_mode_q   <= |(active & is_manual) ||
                         |(cif.closed & func_mask(CF_LOCKED_MANUAL, contact_func,
                                                  coded_mode));
      hold_second_display_q <= |(active & is_manual) ||
                               |(cif.closed & func_mask(CF_LOCKED_MANUAL,
                                                        contact_func, coded_mode));
    end
  end

  // tuning and output action
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tuning_set_two_q   <= 1'b0;
      integral_inhibit_q <= 1'b0;
      action_direct_q    <= 1'b0;
      adaptive_suspend_q <= 1'b0;
      use_pv2_q          <= 1'b0;
    end
    else
    begin
      tuning_set_two_q   <= |(active & is_alt);
      integral_inhibit_q <= |(cif.closed & func_mask(CF_INTEG_INHIBIT, contact_func,
                                                    coded_mode));
      action_direct_q    <= cfg_action_direct ^ |(cif.closed &
                            func_mask(CF_ACTION_REV, contact_func, coded_mode));
      adaptive_suspend_q <= |(cif.closed & func_mask(CF_ADAPT_SUSPEND, contact_func,
                                                    coded_mode));
      use_pv2_q          <= process_input_source && |(cif.closed &
                            func_mask(CF_PROC_SWITCH, contact_func, coded_mode));
    end
  end

  // alarm acknowledge fires on the qualified closing edge only
  assign ack_fire = |(cif.rise & func_mask(CF_ALARM_ACK, contact_func, coded_mode));

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      alarm_ack_q <= '0;
    else
      alarm_ack_q <= ack_fire ? (alarm_active & alarm_ackable) : '0;
  end

  // key mimics and status reporting
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      key_mimic_q     <= '0;
      report_status_q <= '0;
    end
    else
    begin
      key_mimic_q <= '0;
      for (int i = 0; i < N; i++)
        if (cif.closed[i] && contact_func[i] == CF_KEY_MIMIC &&
            !is_coded[i] && key_select[i] <= KEY_MENU)
          key_mimic_q[key_select[i]] <= 1'b1;
      report_status_q <= cif.closed & func_mask(CF_REPORT_ONLY, contact_func,
                                                coded_mode);
    end
  end

  AST_REMOTE_WINS: assert property (@(posedge clk) disable iff (!reset_n)
    |(sp_newest & is_remote) |=> sp_remote_q)
    else $error("remote contact did not select remote setpoint");
  AST_SECOND_SP: assert property (@(posedge clk) disable iff (!reset_n)
    |(sp_newest & is_second) |=> sp_index_q == SP_INDEX_SEC && !sp_remote_q)
    else $error("second setpoint contact not applied");
  AST_ACK_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
    |alarm_ack_q |=> alarm_ack_q == '0)
    else $error("alarm acknowledge repeated");
  AST_ACK_MASK: assert property (@(posedge clk) disable iff (!reset_n)
    (alarm_ack_q & ~$past(alarm_ackable)) == '0)
    else $error("non acknowledgeable alarm acknowledged");
  AST_LOCKED: assert property (@(posedge clk) disable iff (!reset_n)
    locked_req |=> locked_manual_q && manual_mode_q && hold_second_display_q)
    else $error("locked manual contact did not force manual");
  AST_AUTO_RETURN: assert property (@(posedge clk) disable iff (!reset_n)
    !locked_req && !(|(active & is_manual)) |=> !manual_mode_q && !locked_manual_q)
    else $error("manual held with no manual contact closed");
  AST_PV2_GATED: assert property (@(posedge clk) disable iff (!reset_n)
    !process_input_source |=> !use_pv2_q)
    else $error("second process input used without switching source");
  AST_ACTION_REV: assert property (@(posedge clk) disable iff (!reset_n)
    !(|(cif.closed & func_mask(CF_ACTION_REV, contact_func, coded_mode)))
      |=> action_direct_q == $past(cfg_action_direct))
    else $error("output action changed with no reversal contact");
  AST_KEY_SPARE: assert property (@(posedge clk) disable iff (!reset_n)
    !key_mimic_q[NUM_KEYS-1])
    else $error("unused key mimic bit set");
  AST_OVERRIDE: assert property (@(posedge clk) disable iff (!reset_n)
    manual_override && !(|(cif.rise & is_manual)) |=> ((armed_q & is_manual) == '0))
    else $error("overridden manual contact still armed");
  AST_NEWEST_ONEHOT: assert property (@(posedge clk) disable iff (!reset_n)
    $onehot0(sp_newest) && ((sp_newest & ~(active & sp_group)) == '0))
    else $error("setpoint arbitration picked a non requester");
  AST_CODE_REARM: assert property (@(posedge clk) disable iff (!reset_n)
    coded_mode && code_now != code_q |=> code_armed_q)
    else $error("changed code combination did not rearm");
endmodule

// ---- cifd_contact_bank.sv ----
// Purpose: contact bank model, switches or relays on the five inputs
// Assumes: high on contact_raw means the contact is closed
// Notes:   bounce_req gives a three cycle closure, too short to qualify
module cifd_contact_bank #(
  parameter int unsigned N = 5
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] close_req,
  input  wire logic [N-1:0] bounce_req,
  output logic      [N-1:0] contact_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0] bounce_q = '0;
  logic [1:0]   bounce_cnt = 2'h0;

  always @(posedge clk)
  begin
    if (bounce_req != '0)
    begin
      bounce_q   <= bounce_req;
      bounce_cnt <= 2'h2;
    end
    else if (bounce_cnt != 2'h0)
      bounce_cnt <= bounce_cnt - 2'h1;
    else
      bounce_q <= '0;
  end

  assign contact_raw = close_req | bounce_q;
endmodule

// ---- cifd_dispatch_tb_top.sv ----
// Purpose: self-checking bench for the contact input dispatcher
// Assumes: short closure delay parameter, inputs driven on falling edge
// Notes:   each contact change waits long enough to qualify or release
module cifd_dispatch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cifd_pkg::*;
  localparam int D = 8;
  logic clk = 1'b0, reset_n = 1'b0;
  logic [4:0] close_req = '0, bounce_req = '0, contact_raw;
  cifd_func_t [4:0] contact_func = {5{CF_NONE}};
  logic [4:0][2:0] key_select = '0;
  logic [2:0] local_sp_index = 3'h2;
  logic local_sp_remote = 1'b0, sp_override = 1'b0, manual_override = 1'b0;
  logic pid_linked_to_sp = 1'b0, process_input_source = 1'b1, cfg_action_direct = 1'b1;
  logic [3:0] alarm_active = 4'h0, alarm_ackable = 4'h7, alarm_ack_q, ack_seen = 4'h0;
  logic [2:0] sp_index_q;
  logic sp_remote_q, manual_mode_q, locked_manual_q, hold_second_display_q;
  logic tuning_set_two_q, integral_inhibit_q, action_direct_q, adaptive_suspend_q;
  logic use_pv2_q;
  logic [5:0] key_mimic_q;
  logic [4:0] report_status_q;
  int num_errors = 0, checks = 0, cycles = 0, ack_pulses = 0;
  cifd_func_t lvl_func [7] = '{CF_INTEG_INHIBIT, CF_ACTION_REV, CF_ADAPT_SUSPEND,
                               CF_PROC_SWITCH, CF_ALT_TUNING, CF_LOCKED_MANUAL, CF_REPORT_ONLY};

  cifd_contact_bank u_cifd_contact_bank (.clk, .close_req, .bounce_req, .contact_raw);
  cifd_dispatch #(.CLOSE_DELAY_CYCLES(D)) u_cifd_dispatch (
    .clk, .reset_n, .contact_raw, .contact_func, .key_select, .local_sp_index,
    .local_sp_remote, .sp_override, .manual_override, .pid_linked_to_sp,
    .process_input_source, .cfg_action_direct, .alarm_active, .alarm_ackable,
    .sp_index_q, .sp_remote_q, .manual_mode_q, .locked_manual_q, .hold_second_display_q,
    .tuning_set_two_q, .alarm_ack_q, .integral_inhibit_q, .action_direct_q,
    .adaptive_suspend_q, .key_mimic_q, .report_status_q, .use_pv2_q);

  always #4 clk = ~clk;

  task automatic summarize();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ack pulse monitor and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (|alarm_ack_q === 1'b1)
    begin
      ack_pulses++;
      ack_seen = alarm_ack_q;
    end
    if (cycles == 5000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic contacts(input logic [4:0] m);
    @(negedge clk);
    close_req = m;
    wait_n(D + 8);
  endtask

  task automatic pulse_sp(input logic [2:0] idx);
    @(negedge clk);
    local_sp_index = idx;
    sp_override = 1'b1;
    @(negedge clk);
    sp_override = 1'b0;
    wait_n(4);
  endtask

  function automatic logic lvl_out(input int i);
    case (i)
      0: return integral_inhibit_q;
      1: return action_direct_q;
      2: return adaptive_suspend_q;
      3: return use_pv2_q;
      4: return tuning_set_two_q;
      5: return locked_manual_q & manual_mode_q;
      default: return report_status_q[1];
    endcase
  endfunction

  initial
  begin
    wait_n(10);
    reset_n = 1'b1;
    wait_n(2);
    check("reset action", 8'h01, {7'h0, action_direct_q});
    check("reset sp", 8'h02, {5'h0, sp_index_q});
    check("reset manual", 8'h00, {7'h0, manual_mode_q});
    // manual trip on contact 5, bounce first
    contact_func[4] = CF_MANUAL_TRIP;
    bounce_req = 5'h10;
    @(negedge clk);
    bounce_req = 5'h00;
    wait_n(D + 8);
    check("bounce manual", 8'h00, {7'h0, manual_mode_q});
    close_req = 5'h10;
    wait_n(D - 2);
    check("early manual", 8'h00, {7'h0, manual_mode_q});
    wait_n(10);
    check("manual", 8'h01, {7'h0, manual_mode_q});
    check("second display", 8'h01, {7'h0, hold_second_display_q});
    manual_override = 1'b1;
    @(negedge clk);
    manual_override = 1'b0;
    wait_n(D + 4);
    check("manual overridden", 8'h00, {7'h0, manual_mode_q});
    contacts(5'h00);
    contacts(5'h10);
    check("manual rearmed", 8'h01, {7'h0, manual_mode_q});
    contacts(5'h00);
    check("auto again", 8'h00, {7'h0, manual_mode_q});
    contact_func[4] = CF_NONE;
    // level functions on contact 2
    for (int i = 0; i < 7; i++)
    begin
      contact_func[1] = lvl_func[i];
      contacts(5'h02);
      check("level closed", {7'h0, i != 1}, {7'h0, lvl_out(i)});
      contacts(5'h00);
      check("level open", {7'h0, i == 1}, {7'h0, lvl_out(i)});
    end
    // process switch gated by source, tuning override when linked
    process_input_source = 1'b0;
    contact_func[1] = CF_PROC_SWITCH;
    contacts(5'h02);
    check("pv2 not switching", 8'h00, {7'h0, use_pv2_q});
    contacts(5'h00);
    process_input_source = 1'b1;
    contact_func[1] = CF_ALT_TUNING;
    contacts(5'h02);
    pulse_sp(3'h2);
    check("pid unlinked", 8'h01, {7'h0, tuning_set_two_q});
    pid_linked_to_sp = 1'b1;
    pulse_sp(3'h2);
    check("pid linked override", 8'h00, {7'h0, tuning_set_two_q});
    contacts(5'h00);
    pid_linked_to_sp = 1'b0;
    // all locked manual contacts must open
    contact_func[1] = CF_LOCKED_MANUAL;
    contact_func[2] = CF_LOCKED_MANUAL;
    contacts(5'h06);
    contacts(5'h04);
    check("locked one left", 8'h01, {7'h0, manual_mode_q});
    contacts(5'h00);
    check("locked all open", 8'h00, {7'h0, manual_mode_q});
    contact_func[2] = CF_NONE;
    contact_func[1] = CF_NONE;
    // key mimics on contact 3
    contact_func[2] = CF_KEY_MIMIC;
    for (int k = 0; k < 5; k++)
    begin
      key_select[2] = k[2:0];
      contacts(5'h04);
      check("key closed", 8'h01 << k, {2'h0, key_mimic_q});
      contacts(5'h00);
      check("key open", 8'h00, {2'h0, key_mimic_q});
    end
    contact_func[2] = CF_NONE;
    // alarm acknowledge on contact 4
    contact_func[3] = CF_ALARM_ACK;
    alarm_active = 4'h3;
    contacts(5'h08);
    check("ack count", 8'h01, ack_pulses[7:0]);
    check("ack alarms", 8'h03, {4'h0, ack_seen});
    alarm_active = 4'hf;
    wait_n(20);
    check("ack held", 8'h01, ack_pulses[7:0]);
    contacts(5'h00);
    contacts(5'h08);
    check("ack rearmed", 8'h02, ack_pulses[7:0]);
    check("ack alarms 2", 8'h07, {4'h0, ack_seen});
    contacts(5'h00);
    contact_func[3] = CF_NONE;
    // second and remote setpoints
    contact_func[0] = CF_SECOND_SP;
    contact_func[1] = CF_REMOTE_SP;
    contacts(5'h01);
    check("second sp", {5'h0, SP_INDEX_SEC}, {5'h0, sp_index_q});
    contacts(5'h03);
    check("remote newest", 8'h01, {7'h0, sp_remote_q});
    contacts(5'h01);
    check("remote open", 8'h00, {7'h0, sp_remote_q});
    contacts(5'h00);
    check("sp reverts", 8'h02, {5'h0, sp_index_q});
    contacts(5'h01);
    pulse_sp(3'h5);
    check("sp override", 8'h05, {5'h0, sp_index_q});
    contacts(5'h00);
    contacts(5'h01);
    check("second rearmed", {5'h0, SP_INDEX_SEC}, {5'h0, sp_index_q});
    contacts(5'h00);
    // coded setpoints on contacts 1 to 4
    contact_func[0] = CF_CODED_SP;
    contact_func[1] = CF_NONE;
    for (int c = 1; c <= 8; c++)
    begin
      contacts({1'b0, c[3:0]});
      check("coded sp", 8'(c - 1), {5'h0, sp_index_q});
    end
    contacts(5'h00);
    check("code zero", 8'h05, {5'h0, sp_index_q});
    contacts(5'h03);
    check("code three", 8'h02, {5'h0, sp_index_q});
    pulse_sp(3'h6);
    wait_n(D + 8);
    check("coded held off", 8'h06, {5'h0, sp_index_q});
    contacts(5'h05);
    check("coded rearmed", 8'h04, {5'h0, sp_index_q});
    contacts(5'h00);
    summarize();
  end
endmodule
